// ---- icu_pkg.sv ----
// constants, field layout and mode codes of the internal clock unit
// assumes an 8-bit register port with four word addresses
package icu_pkg;

	// ==========================================================
	// register port
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam logic [1:0] ADDR_CTRL1 = 2'h0;
	localparam logic [1:0] ADDR_CTRL2 = 2'h1;
	localparam logic [1:0] ADDR_TRIM = 2'h2;
	localparam logic [1:0] ADDR_STATUS = 2'h3;

	// ==========================================================
	// field positions
	localparam int C1_SRC_SEL = 6;
	localparam int C1_RDIV_LSB = 3;
	localparam int C1_KEEP = 0;
	localparam logic [7:0] C1_ONES = 8'h06;
	localparam int C2_BUS_DIV_LSB = 6;
	localparam int C2_PD_SEL = 3;
	localparam int ST_LOCK = 4;
	localparam int ST_MODE = 2;
	localparam int ST_FTRIM = 0;

	// ==========================================================
	// reset values
	localparam logic SRC_SEL_RST = 1'b0;
	localparam logic [2:0] RDIV_RST = 3'h0;
	localparam logic KEEP_RST = 1'b0;
	localparam logic [1:0] BUS_DIV_RST = 2'h1;
	localparam logic PD_SEL_RST = 1'b0;
	localparam logic [7:0] TRIM_RST = 8'h80;
	localparam logic FTRIM_RST = 1'b0;

	// ==========================================================
	// loop monitor
	localparam int DIV_CW = 7;
	localparam int LOCK_CW = 11;
	localparam logic [10:0] LOOP_MULT = 11'h200;
	localparam logic [10:0] LOCK_SAT = 11'h7FF;

	typedef enum logic [1:0] {
		ICU_MODE_ENG = 2'b00,
		ICU_MODE_BYP = 2'b01,
		ICU_MODE_BYP_PD = 2'b10,
		ICU_MODE_STOP = 2'b11
	} icu_mode_t;

	// last count value of a divide by two to the power shift
	function automatic logic [6:0] icu_ratio_max(input logic [2:0] shift);
		icu_ratio_max = (7'h01 << shift) - 7'h01;
	endfunction : icu_ratio_max

	// run mode chosen by source select and low power select
	function automatic icu_mode_t icu_run_mode(input logic src_sel, input logic pd_sel);
		if (!src_sel)
			icu_run_mode = ICU_MODE_ENG;
		else if (pd_sel)
			icu_run_mode = ICU_MODE_BYP_PD;
		else
			icu_run_mode = ICU_MODE_BYP;
	endfunction : icu_run_mode

endpackage : icu_pkg

// ---- icu_div_if.sv ----
// tick divider hookup between the clock unit and its dividers
// assumes ticks are one-cycle enables on the system clock
`timescale 1ns/1ns
interface icu_div_if;
	logic tick_in;
	logic clear;
	logic [2:0] shift;
	logic tick_out;
	modport div_side(input tick_in, input clear, input shift, output tick_out);
	modport user_side(output tick_in, output clear, output shift, input tick_out);
endinterface : icu_div_if

// ---- icu_tick_div.sv ----
// power-of-two tick divider, 1 to 128
// assumes input ticks are one-cycle enables; output is combinational
`timescale 1ns/1ns
module icu_tick_div #(
	parameter int CW = 7
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	icu_div_if.div_side port
);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic [CW-1:0] lim;

	// ==========================================================
	// counter
	// compare with >= so a smaller ratio acts on the next tick
	always_comb begin
		lim = CW'(icu_pkg::icu_ratio_max(port.shift));
		nxt_cnt = cnt_ff;
		port.tick_out = 1'b0;
		if (port.clear) begin
			nxt_cnt = '0;
		end else if (port.tick_in) begin
			if (cnt_ff >= lim) begin
				nxt_cnt = '0;
				port.tick_out = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

endmodule : icu_tick_div

// ---- icu_clock_ctrl.sv ----
// internal clock unit: mode control, bus divider, debug clock, loop monitor
// assumes oscillator and reference edges arrive as one-cycle ticks
// on clk_sys_i, and stop_i / dbg_active_i are synchronous levels
//
// Overview of operation
// - system clock tick rate is twice bus rate
// - selected source always passes the bus divider
// - divider select in control two bits 7:6
// - codes give 1, 2, 4, 8; reset 2
// - control one bits 2:1 read one
// - reset enters loop engaged mode
// - source select bit 6 picks loop or reference
// - source select zero gives loop engaged mode
// - source select one gives a bypassed mode
// - engaged: output and debug clock from loop
// - bypassed: loop on, output from reference
// - low power bypass: loop off, no debug clock
// - stop: no loop, system or debug clock
// - in bypass, low power bit stops loop unless debugging
// - stop keep bit holds reference running
// - debug clock is oscillator divided by two
// - reference period has nine trim bits
// - three-bit reference divider select
// - loop locks to 512 times divided reference
// - divider changes act immediately
`timescale 1ns/1ns
module icu_clock_ctrl (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [7:0] rd_data_o,
	input wire logic dco_tick_i,
	input wire logic ref_tick_i,
	input wire logic stop_i,
	input wire logic dbg_active_i,
	output logic sys_clk_en_o,
	output logic bus_clk_en_o,
	output logic dbg_clk_en_o,
	output logic loop_enable_o,
	output logic ref_enable_o,
	output logic loop_faster_o,
	output logic loop_slower_o,
	output logic [8:0] ref_trim_o,
	output logic [1:0] mode_o
);

	// ==========================================================
	// declarations
	logic src_sel_ff, nxt_src_sel;
	logic [2:0] rdiv_ff, nxt_rdiv;
	logic keep_ff, nxt_keep;
	logic [1:0] bus_div_ff, nxt_bus_div;
	logic pd_sel_ff, nxt_pd_sel;
	logic [7:0] trim_ff, nxt_trim;
	logic ftrim_ff, nxt_ftrim;
	logic [7:0] rd_data_ff, nxt_rd_data;
	icu_pkg::icu_mode_t mode_ff, nxt_mode;
	logic sys_ff, nxt_sys;
	logic bus_ff, nxt_bus;
	logic bus_ph_ff, nxt_bus_ph;
	logic dbg_ff, nxt_dbg;
	logic dbg_ph_ff, nxt_dbg_ph;
	logic loop_ff, nxt_loop;
	logic ref_en_ff, nxt_ref_en;
	logic [10:0] lock_cnt_ff, nxt_lock_cnt;
	logic faster_ff, nxt_faster;
	logic slower_ff, nxt_slower;
	logic locked_ff, nxt_locked;
	logic loop_on;
	logic dbg_on;
	logic src_tick;

	icu_div_if bus_if ();
	icu_div_if ref_if ();

	// ==========================================================
	// register port
	always_comb begin
		nxt_src_sel = src_sel_ff;
		nxt_rdiv = rdiv_ff;
		nxt_keep = keep_ff;
		nxt_bus_div = bus_div_ff;
		nxt_pd_sel = pd_sel_ff;
		nxt_trim = trim_ff;
		nxt_ftrim = ftrim_ff;
		nxt_rd_data = 8'h00;
		if (wr_en_i) begin
			unique case (addr_i)
				icu_pkg::ADDR_CTRL1: begin
					nxt_src_sel = wr_data_i[icu_pkg::C1_SRC_SEL];
					nxt_rdiv = wr_data_i[icu_pkg::C1_RDIV_LSB +: 3];
					nxt_keep = wr_data_i[icu_pkg::C1_KEEP];
				end
				icu_pkg::ADDR_CTRL2: begin
					nxt_bus_div = wr_data_i[icu_pkg::C2_BUS_DIV_LSB +: 2];
					nxt_pd_sel = wr_data_i[icu_pkg::C2_PD_SEL];
				end
				icu_pkg::ADDR_TRIM: begin
					nxt_trim = wr_data_i;
				end
				icu_pkg::ADDR_STATUS: begin
					nxt_ftrim = wr_data_i[icu_pkg::ST_FTRIM];
				end
			endcase
		end
		if (rd_en_i) begin
			unique case (addr_i)
				icu_pkg::ADDR_CTRL1: begin
					nxt_rd_data[icu_pkg::C1_SRC_SEL] = src_sel_ff;
					nxt_rd_data[icu_pkg::C1_RDIV_LSB +: 3] = rdiv_ff;
					nxt_rd_data[icu_pkg::C1_KEEP] = keep_ff;
					nxt_rd_data = nxt_rd_data | icu_pkg::C1_ONES;
				end
				icu_pkg::ADDR_CTRL2: begin
					nxt_rd_data[icu_pkg::C2_BUS_DIV_LSB +: 2] = bus_div_ff;
					nxt_rd_data[icu_pkg::C2_PD_SEL] = pd_sel_ff;
				end
				icu_pkg::ADDR_TRIM: begin
					nxt_rd_data = trim_ff;
				end
				icu_pkg::ADDR_STATUS: begin
					nxt_rd_data[icu_pkg::ST_LOCK] = locked_ff;
					nxt_rd_data[icu_pkg::ST_MODE] = (mode_ff == icu_pkg::ICU_MODE_BYP) ||
						(mode_ff == icu_pkg::ICU_MODE_BYP_PD);
					nxt_rd_data[icu_pkg::ST_FTRIM] = ftrim_ff;
				end
			endcase
		end
	end

	// trim is not self-restoring; software reloads the factory value
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_sel_ff <= icu_pkg::SRC_SEL_RST;
			rdiv_ff <= icu_pkg::RDIV_RST;
			keep_ff <= icu_pkg::KEEP_RST;
			bus_div_ff <= icu_pkg::BUS_DIV_RST;
			pd_sel_ff <= icu_pkg::PD_SEL_RST;
			trim_ff <= icu_pkg::TRIM_RST;
			ftrim_ff <= icu_pkg::FTRIM_RST;
			rd_data_ff <= 8'h00;
		end else begin
			src_sel_ff <= nxt_src_sel;
			rdiv_ff <= nxt_rdiv;
			keep_ff <= nxt_keep;
			bus_div_ff <= nxt_bus_div;
			pd_sel_ff <= nxt_pd_sel;
			trim_ff <= nxt_trim;
			ftrim_ff <= nxt_ftrim;
			rd_data_ff <= nxt_rd_data;
		end
	end

	// ==========================================================
	// mode and clock generation
	// stop leaves the control bits alone, so leaving stop resumes the old mode
	always_comb begin
		if (stop_i)
			nxt_mode = icu_pkg::ICU_MODE_STOP;
		else
			nxt_mode = icu_pkg::icu_run_mode(src_sel_ff, pd_sel_ff);
		loop_on = (mode_ff == icu_pkg::ICU_MODE_ENG) || (mode_ff == icu_pkg::ICU_MODE_BYP) ||
			((mode_ff == icu_pkg::ICU_MODE_BYP_PD) && dbg_active_i);
		// debug clock withheld in low power bypass even when debugging
		dbg_on = (mode_ff == icu_pkg::ICU_MODE_ENG) ||
			(mode_ff == icu_pkg::ICU_MODE_BYP);
		unique case (mode_ff)
			icu_pkg::ICU_MODE_ENG: src_tick = dco_tick_i;
			icu_pkg::ICU_MODE_BYP: src_tick = ref_tick_i;
			icu_pkg::ICU_MODE_BYP_PD: src_tick = ref_tick_i;
			icu_pkg::ICU_MODE_STOP: src_tick = 1'b0;
		endcase
		bus_if.tick_in = src_tick;
		bus_if.clear = (mode_ff == icu_pkg::ICU_MODE_STOP);
		bus_if.shift = {1'b0, bus_div_ff};
		nxt_sys = bus_if.tick_out;
		nxt_bus_ph = bus_if.tick_out ? !bus_ph_ff : bus_ph_ff;
		nxt_bus = bus_if.tick_out && bus_ph_ff;
		nxt_dbg_ph = (dco_tick_i && dbg_on) ? !dbg_ph_ff : dbg_ph_ff;
		nxt_dbg = dco_tick_i && dbg_on && dbg_ph_ff;
		nxt_loop = loop_on;
		nxt_ref_en = (mode_ff != icu_pkg::ICU_MODE_STOP) || keep_ff;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_ff <= icu_pkg::ICU_MODE_ENG;
			sys_ff <= 1'b0;
			bus_ff <= 1'b0;
			bus_ph_ff <= 1'b0;
			dbg_ff <= 1'b0;
			dbg_ph_ff <= 1'b0;
			loop_ff <= 1'b0;
			ref_en_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			sys_ff <= nxt_sys;
			bus_ff <= nxt_bus;
			bus_ph_ff <= nxt_bus_ph;
			dbg_ff <= nxt_dbg;
			dbg_ph_ff <= nxt_dbg_ph;
			loop_ff <= nxt_loop;
			ref_en_ff <= nxt_ref_en;
		end
	end

	icu_tick_div #(
		.CW(icu_pkg::DIV_CW)
	) u_bus_div (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.port(bus_if.div_side)
	);

	// ==========================================================
	// loop frequency monitor
	// oscillator ticks counted per divided reference period
	always_comb begin
		ref_if.tick_in = ref_tick_i && loop_on;
		ref_if.clear = !loop_on;
		ref_if.shift = rdiv_ff;
		nxt_lock_cnt = lock_cnt_ff;
		nxt_faster = faster_ff;
		nxt_slower = slower_ff;
		nxt_locked = locked_ff;
		if (!loop_on) begin
			nxt_lock_cnt = 11'h000;
			nxt_faster = 1'b0;
			nxt_slower = 1'b0;
			nxt_locked = 1'b0;
		end else if (ref_if.tick_out) begin
			nxt_faster = lock_cnt_ff < icu_pkg::LOOP_MULT;
			nxt_slower = lock_cnt_ff > icu_pkg::LOOP_MULT;
			nxt_locked = lock_cnt_ff == icu_pkg::LOOP_MULT;
			nxt_lock_cnt = {10'h000, dco_tick_i};
		end else if (dco_tick_i && (lock_cnt_ff != icu_pkg::LOCK_SAT)) begin
			nxt_lock_cnt = lock_cnt_ff + 11'h001;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_cnt_ff <= 11'h000;
			faster_ff <= 1'b0;
			slower_ff <= 1'b0;
			locked_ff <= 1'b0;
		end else begin
			lock_cnt_ff <= nxt_lock_cnt;
			faster_ff <= nxt_faster;
			slower_ff <= nxt_slower;
			locked_ff <= nxt_locked;
		end
	end

	icu_tick_div #(
		.CW(icu_pkg::DIV_CW)
	) u_ref_div (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.port(ref_if.div_side)
	);

	// ==========================================================
	// outputs
	assign rd_data_o = rd_data_ff;
	assign sys_clk_en_o = sys_ff;
	assign bus_clk_en_o = bus_ff;
	assign dbg_clk_en_o = dbg_ff;
	assign loop_enable_o = loop_ff;
	assign ref_enable_o = ref_en_ff;
	assign loop_faster_o = faster_ff;
	assign loop_slower_o = slower_ff;
	assign ref_trim_o = {trim_ff, ftrim_ff};
	assign mode_o = mode_ff;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	a_bus_half_rate: assert property (bus_clk_en_o |-> sys_clk_en_o)
		else $error("bus tick without system tick");
	a_div_by_one: assert property ((bus_div_ff == 2'h0) && src_tick
		|=> sys_clk_en_o)
		else $error("divide by one dropped a tick");
	a_ctrl1_ones: assert property (rd_en_i && (addr_i == icu_pkg::ADDR_CTRL1)
		|=> ((rd_data_o & icu_pkg::C1_ONES) == icu_pkg::C1_ONES))
		else $error("control one fixed bits not one");
	a_mode_engaged: assert property (!stop_i && !src_sel_ff
		|=> (mode_ff == icu_pkg::ICU_MODE_ENG))
		else $error("engaged mode not entered");
	a_bypass_loop_on: assert property ((mode_ff == icu_pkg::ICU_MODE_BYP)
		|=> loop_enable_o && ref_enable_o)
		else $error("bypass mode lost loop or reference");
	a_low_power_off: assert property ((mode_ff == icu_pkg::ICU_MODE_BYP_PD)
		|=> !dbg_clk_en_o && (loop_enable_o == $past(dbg_active_i)))
		else $error("low power loop or debug clock wrong");
	a_stop_quiet: assert property ((mode_ff == icu_pkg::ICU_MODE_STOP)
		|=> !sys_clk_en_o && !dbg_clk_en_o && !loop_enable_o)
		else $error("clock running in stop");
	a_dbg_half_rate: assert property (dbg_clk_en_o |=> !dbg_clk_en_o)
		else $error("debug clock faster than half");
	a_lock_flag: assert property (ref_if.tick_out && loop_on
		&& (lock_cnt_ff == icu_pkg::LOOP_MULT) |=> locked_ff && !loop_faster_o)
		else $error("lock not flagged at target count");

	c_enter_stop: cover property ((mode_ff != icu_pkg::ICU_MODE_STOP) ##1
		(mode_ff == icu_pkg::ICU_MODE_STOP));
	c_low_power: cover property (mode_ff == icu_pkg::ICU_MODE_BYP_PD);
	c_locked: cover property (locked_ff);
	c_div_eight: cover property ((bus_div_ff == 2'h3) && bus_clk_en_o);

endmodule : icu_clock_ctrl

// ---- icu_osc_model.sv ----
// behavioural oscillator and reference of the clock unit, as one-cycle ticks
// assumes enables from the clock unit; tick periods are set by the bench
`timescale 1ns/1ns
module icu_osc_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic loop_enable_i,
	input wire logic ref_enable_i,
	input wire logic [11:0] dco_per_i,
	input wire logic [11:0] ref_per_i,
	output logic dco_tick_o,
	output logic ref_tick_o
);
	// ==========================================================
	// tick counters
	// a disabled source is silent: no stale tick leaks out of it
	logic [11:0] dco_cnt_ff;
	logic [11:0] ref_cnt_ff;
	logic dco_end;
	logic ref_end;
	assign dco_end = loop_enable_i && (dco_cnt_ff >= dco_per_i - 12'h001);
	assign ref_end = ref_enable_i && (ref_cnt_ff >= ref_per_i - 12'h001);
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dco_cnt_ff <= 12'h000;
			ref_cnt_ff <= 12'h000;
			dco_tick_o <= 1'b0;
			ref_tick_o <= 1'b0;
		end else begin
			dco_cnt_ff <= (dco_end || !loop_enable_i) ? 12'h000 : dco_cnt_ff + 12'h001;
			ref_cnt_ff <= (ref_end || !ref_enable_i) ? 12'h000 : ref_cnt_ff + 12'h001;
			dco_tick_o <= dco_end;
			ref_tick_o <= ref_end;
		end
	end
endmodule : icu_osc_model

// ---- icu_clock_ctrl_tb.sv ----
// self-checking bench of the internal clock unit
// assumes the oscillator model in icu_osc_model and a 100 MHz clock
`timescale 1ns/1ns
module icu_clock_ctrl_tb;
	logic clk_sys_i = 1'b0;
	logic rst_n_i;
	logic [1:0] addr;
	logic [7:0] wdat;
	logic wen;
	logic ren;
	logic [7:0] rdat;
	logic controlled_oscillator;
	logic rtk;
	logic stop;
	logic dbg_act;
	logic sys;
	logic bus;
	logic dbg;
	logic loop_en;
	logic ref_en;
	logic faster;
	logic slower;
	logic [8:0] trim;
	logic [1:0] mode;
	logic [11:0] dco_per;
	logic [11:0] ref_per;
	logic [2:0] tk;
	logic [7:0] d;
	int errors;
	int checks_done;
	int n;
	int c;
	assign tk = {dbg, bus, sys};

	icu_clock_ctrl uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr),
		.wr_data_i(wdat), .wr_en_i(wen), .rd_en_i(ren), .rd_data_o(rdat),
		.dco_tick_i(controlled_oscillator), .ref_tick_i(rtk), .stop_i(stop), .dbg_active_i(dbg_act),
		.sys_clk_en_o(sys), .bus_clk_en_o(bus), .dbg_clk_en_o(dbg),
		.loop_enable_o(loop_en), .ref_enable_o(ref_en), .loop_faster_o(faster),
		.loop_slower_o(slower), .ref_trim_o(trim), .mode_o(mode));
	icu_osc_model osc (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.loop_enable_i(loop_en), .ref_enable_i(ref_en), .dco_per_i(dco_per),
		.ref_per_i(ref_per), .dco_tick_o(controlled_oscillator), .ref_tick_o(rtk));

	// ==========================================================
	// clock and watchdog
	always #5 clk_sys_i = ~clk_sys_i;
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		errors++;
		finish_test();
	end

	// ==========================================================
	// tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic idle(input int k);
		repeat (k) @(posedge clk_sys_i);
	endtask : idle
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		addr <= a;
		wdat <= v;
		wen <= 1'b1;
		@(posedge clk_sys_i);
		wen <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		addr <= a;
		ren <= 1'b1;
		@(posedge clk_sys_i);
		ren <= 1'b0;
		@(posedge clk_sys_i);
		v = rdat;
	endtask : rd
	// cycles between two ticks; first pass only syncs to a tick
	task automatic gap(input int which, output int k);
		repeat (2) begin
			k = 0;
			do begin
				@(posedge clk_sys_i);
				k++;
			end while (tk[which] !== 1'b1 && k < 3000);
		end
	endtask : gap
	task automatic ticks(input int k, output int cnt);
		cnt = 0;
		repeat (k) begin
			@(posedge clk_sys_i);
			if (tk !== 3'h0)
				cnt++;
		end
	endtask : ticks
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	// ==========================================================
	// tests
	initial begin
		rst_n_i = 1'b0;
		addr = 2'h0;
		wdat = 8'h00;
		wen = 1'b0;
		ren = 1'b0;
		stop = 1'b0;
		dbg_act = 1'b0;
		dco_per = 12'h002;
		ref_per = 12'h003;
		errors = 0;
		checks_done = 0;
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		idle(3);
		check("mode", 16'(mode), 16'(icu_pkg::ICU_MODE_ENG));
		check("loop_en", 16'(loop_en), 16'h0001);
		rd(icu_pkg::ADDR_CTRL1, d);
		check("ctrl1", 16'(d), 16'h0006);
		rd(icu_pkg::ADDR_CTRL2, d);
		check("ctrl2", 16'(d), 16'h0040);
		wr(icu_pkg::ADDR_CTRL1, 8'hB9);
		rd(icu_pkg::ADDR_CTRL1, d);
		check("ctrl1 wr", 16'(d), 16'h003F);
		$display("test regs done");
		// every divider code, engaged on the loop
		for (c = 0; c < 4; c++) begin
			wr(icu_pkg::ADDR_CTRL2, {c[1:0], 6'h00});
			gap(0, n);
			check("sys gap", 16'(n), 16'(2 << c));
			gap(1, n);
			check("bus gap", 16'(n), 16'(4 << c));
		end
		gap(2, n);
		check("dbg gap", 16'(n), 16'h0004);
		$display("test divider done");
		// bypassed on the reference, divide by 8 still set
		wr(icu_pkg::ADDR_CTRL1, 8'h40);
		idle(3);
		check("mode", 16'(mode), 16'(icu_pkg::ICU_MODE_BYP));
		check("loop_en", 16'(loop_en), 16'h0001);
		rd(icu_pkg::ADDR_STATUS, d);
		check("status", 16'(d), 16'h0004);
		gap(0, n);
		check("sys gap", 16'(n), 16'h0018);
		gap(2, n);
		check("dbg gap", 16'(n), 16'h0004);
		wr(icu_pkg::ADDR_CTRL2, 8'h08);
		idle(3);
		check("mode", 16'(mode), 16'(icu_pkg::ICU_MODE_BYP_PD));
		check("loop_en", 16'(loop_en), 16'h0000);
		gap(0, n);
		check("sys gap", 16'(n), 16'h0003);
		dbg_act <= 1'b1;
		idle(4);
		check("loop_en", 16'(loop_en), 16'h0001);
		dbg_act <= 1'b0;
		wr(icu_pkg::ADDR_CTRL1, 8'h00);
		idle(3);
		check("mode", 16'(mode), 16'(icu_pkg::ICU_MODE_ENG));
		gap(0, n);
		check("sys gap", 16'(n), 16'h0002);
		$display("test modes done");
		// stop with and without keeping the reference
		for (c = 0; c < 2; c++) begin
			wr(icu_pkg::ADDR_CTRL1, {7'h00, c[0]});
			stop <= 1'b1;
			idle(4);
			check("mode", 16'(mode), 16'(icu_pkg::ICU_MODE_STOP));
			check("loop_en", 16'(loop_en), 16'h0000);
			check("ref_en", 16'(ref_en), 16'(c[0]));
			ticks(40, n);
			check("stop ticks", 16'(n), 16'h0000);
			stop <= 1'b0;
			idle(4);
			check("mode", 16'(mode), 16'(icu_pkg::ICU_MODE_ENG));
		end
		$display("test stop done");
		// lock monitor: {ctrl1, reference period, faster, slower}
		for (c = 0; c < 4; c++) begin
			logic [23:0] row;
			row = c == 0 ? {8'h00, 12'd1200, 4'h1} : c == 1 ? {8'h00, 12'd800, 4'h2} :
				c == 2 ? {8'h00, 12'd1024, 4'h0} : {8'h08, 12'd512, 4'h0};
			wr(icu_pkg::ADDR_CTRL1, row[23:16]);
			ref_per <= row[15:4];
			idle(3 * 2 * int'(row[15:4]));
			check("faster", 16'(faster), 16'(row[1]));
			check("slower", 16'(slower), 16'(row[0]));
		end
		rd(icu_pkg::ADDR_STATUS, d);
		check("status", 16'(d), 16'h0010);
		$display("test lock done");
		wr(icu_pkg::ADDR_TRIM, 8'h55);
		wr(icu_pkg::ADDR_STATUS, 8'h01);
		idle(2);
		check("trim", 16'(trim), 16'h00AB);
		$display("test trim done");
		finish_test();
	end
endmodule : icu_clock_ctrl_tb
